// >>> hw/osl_strap_latch.sv
/*
 * osl_strap_latch: latches board straps once after reset, decodes them
 * into configuration outputs, times the management quiet window and
 * offers the results over a classic wishbone slave.
 * assumes straps are steady around the reset release and synchronous to
 * mclk_i; the wishbone master keeps its request until it sees ack.
 */
`timescale 1ns/10ps
module osl_strap_latch
	import osl_pkg::*;
#(
	parameter int          QUIET_LEN     = QUIET_TICKS,  // quiet time in ticks
	parameter logic [23:0] LEGACY_LOW    = 24'h000000    // legacy low leds
)
(
	input  wire logic             mclk_i,                     // system clock
	input  wire logic             rst_n_i,                    // async reset
	// ****************************************************************
	// strap pins, sampled once
	// ****************************************************************
	input  wire logic [1:0]       led_display_select_i,       // led mode
	input  wire logic             copper_flow_ctrl_strap_i,   // copper pause
	input  wire logic             serial_led_addr_bit4_i,     // address bit 4
	input  wire logic             serial_led_addr_bit3_i,     // address bit 3
	input  wire logic             led_active_low_select_i,    // led polarity
	input  wire logic             repeater_select_i,          // repeater pin
	input  wire logic             rx_delay_strap_i,           // receive delay
	input  wire logic             fiber_flow_ctrl_strap_i,    // fiber pause
	input  wire logic             test_disable_strap_i,       // test disable
	input  wire logic             forced_mode_led_select_i,   // forced led pin
	input  wire logic             fiber_duplex_strap_i,       // fiber duplex
	input  wire logic             tx_delay_strap_i,           // transmit delay
	input  wire logic             slew_strap_i,               // slew select
	input  wire logic             scan_select_strap_i,        // scan select
	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	input  wire logic             wb_cyc_i,                   // cycle
	input  wire logic             wb_stb_i,                   // strobe
	input  wire logic             wb_we_i,                    // write enable
	input  wire logic [WB_AW-1:0] wb_adr_i,                   // byte address
	input  wire logic [3:0]       wb_sel_i,                   // byte lanes
	input  wire logic [31:0]      wb_dat_i,                   // write data
	output logic      [31:0]      wb_dat_o,                   // read data
	output logic                  wb_ack_o,                   // acknowledge
	// ****************************************************************
	// decoded configuration
	// ****************************************************************
	output logic                  cfg_valid_o,                // straps latched
	output logic                  direct_led_mode_o,          // direct leds
	output logic      [1:0]       led_mode_o,                 // led mode code
	output logic                  copper_flow_ctrl_o,         // copper pause
	output logic                  fiber_flow_ctrl_o,          // fiber pause
	output logic                  fiber_full_duplex_o,        // fiber duplex
	output logic                  repeater_mode_o,            // no loopback
	output logic                  forced_led_on_o,            // leds pre link
	output logic      [1:0]       phy_addr_hi_o,              // address 4:3
	output logic      [23:0]      led_active_low_o,           // per led level
	output logic                  rx_delay_en_o,              // receive delay
	output logic                  tx_delay_en_o,              // transmit delay
	output logic                  slew_fast_o,                // fast slew
	output logic                  test_mode_o,                // testing mode
	output logic                  scan_mode_o,                // scan mode
	output logic                  ref_tick_o,                 // 25 mhz enable
	output logic                  mgmt_ready_o                // access allowed
);

	// ****************************************************************
	// strap decode
	// ****************************************************************

	// turns raw straps into the configuration the rest of the chip uses
	function automatic osl_cfg_type decode(input osl_straps_type s);
		osl_cfg_type c;  // result
		logic        d;  // direct led mode
		d = (s.led_display == LED_DIRECT);
		c.direct_led = d;
		c.led_mode   = s.led_display;
		// serial-only straps fall back to their idle values when direct
		c.copper_flow = d ? STRAP_RST.copper_flow : s.copper_flow;
		c.fiber_flow  = d ? STRAP_RST.fiber_flow : s.fiber_flow;
		c.fiber_dup   = d ? STRAP_RST.fiber_dup : s.fiber_dup;
		c.repeater    = d ? STRAP_RST.repeater : s.repeater;
		c.forced_led  = d ? 1'b0 : s.forced_led;
		// shared pins move into the address in direct mode
		if (d)
			c.addr_hi = {s.repeater, s.forced_led};
		else
			c.addr_hi = {s.addr_bit4, s.addr_bit3};
		c.all_low   = s.active_low;
		c.rx_delay  = s.rx_delay;
		c.tx_delay  = s.tx_delay;
		c.slew_fast = s.slew_fast;
		c.test_mode = ~s.test_dis;
		c.scan_mode = s.scan;
		return c;
	endfunction

	// configuration seen before the first latch edge
	localparam osl_cfg_type CFG_RST = decode(STRAP_RST);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic           captured;     // straps taken since reset
		osl_straps_type straps;       // raw latched straps
		osl_cfg_type    cfg;          // decoded configuration
		logic [QCW-1:0] quiet_cnt;    // reference ticks since latch
		logic           quiet_done;   // quiet window elapsed
		logic           mgmt_enable;  // software gate on ready
		logic           ack;          // wishbone acknowledge
		logic [31:0]    rdat;         // wishbone read data
	} osl_state_type;

	localparam osl_state_type STATE_RST = '{
		captured:    1'b0,
		straps:      STRAP_RST,
		cfg:         CFG_RST,
		quiet_cnt:   '0,
		quiet_done:  1'b0,
		mgmt_enable: CTRL_ENABLE_RST,
		ack:         1'b0,
		rdat:        32'h00000000
	};

	osl_state_type  state;       // registered state
	osl_state_type  next_state;  // next state
	osl_straps_type pins;        // straps as they stand now
	logic           ref_tick;    // one pulse per reference period
	logic           req;         // new wishbone request
	logic [7:0]     word_adr;    // aligned byte address

	// ****************************************************************
	// reference tick
	// ****************************************************************

	// the 200 mhz clock is cut to the 25 mhz reference rate; the quiet
	// window is counted in reference ticks so it matches the pad timing
	osl_tick_div #(
		.DIV    (REF_DIV)
	) u_ref_div (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.tick_o  (ref_tick)
	);

	// ****************************************************************
	// request and pin gathering
	// ****************************************************************

	// gather the straps into one word
	always_comb
	begin
		pins.led_display = led_display_select_i;
		pins.copper_flow = copper_flow_ctrl_strap_i;
		pins.addr_bit4   = serial_led_addr_bit4_i;
		pins.addr_bit3   = serial_led_addr_bit3_i;
		pins.active_low  = led_active_low_select_i;
		pins.repeater    = repeater_select_i;
		pins.rx_delay    = rx_delay_strap_i;
		pins.fiber_flow  = fiber_flow_ctrl_strap_i;
		pins.test_dis    = test_disable_strap_i;
		pins.forced_led  = forced_mode_led_select_i;
		pins.fiber_dup   = fiber_duplex_strap_i;
		pins.tx_delay    = tx_delay_strap_i;
		pins.slew_fast   = slew_strap_i;
		pins.scan        = scan_select_strap_i;
	end

	// a request is new while ack is low; the ack cycle ends it
	assign req      = wb_cyc_i & wb_stb_i & ~state.ack;
	assign word_adr = {wb_adr_i[WB_AW-1:2], 2'b00};

	// ****************************************************************
	// next state
	// ****************************************************************

	always_comb
	begin
		next_state = state;
		next_state.ack = 1'b0;

		// first edge after the reset release takes the straps; they are
		// not looked at again, so later led toggling on the shared pins
		// cannot disturb the configuration
		if (!state.captured)
		begin
			next_state.captured = 1'b1;
			next_state.straps   = pins;
		end

		// configuration follows the latched straps only
		next_state.cfg = decode(next_state.straps);

		// quiet window starts once the straps are in
		if (state.captured && !state.quiet_done && ref_tick)
		begin
			if (state.quiet_cnt == QCW'(QUIET_LEN - 1))
				next_state.quiet_done = 1'b1;
			else
				next_state.quiet_cnt = state.quiet_cnt + 1'b1;
		end

		// wishbone: one wait state, ack for exactly one cycle
		if (req)
		begin
			next_state.ack  = 1'b1;
			next_state.rdat = 32'h00000000;
			case (word_adr)
				REG_CONFIG:
					next_state.rdat[15:0] = state.cfg;
				REG_STRAPS:
					next_state.rdat[14:0] = state.straps;
				REG_STATUS:
				begin
					next_state.rdat[STAT_CAPTURED] = state.captured;
					next_state.rdat[STAT_QUIET]    = state.quiet_done;
					next_state.rdat[STAT_READY]    = state.quiet_done
						& state.mgmt_enable;
				end
				REG_CTRL:
				begin
					next_state.rdat[CTRL_ENABLE] = state.mgmt_enable;
					// only the low lane holds control bits
					if (wb_we_i && wb_sel_i[0])
					begin
						next_state.mgmt_enable = wb_dat_i[CTRL_ENABLE];
						// restart wins over a tick in the same cycle
						if (wb_dat_i[CTRL_RESTART])
						begin
							next_state.quiet_cnt  = '0;
							next_state.quiet_done = 1'b0;
						end
					end
				end
				default:
					// unmapped: acked, reads zero, writes dropped
					next_state.rdat = 32'h00000000;
			endcase
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************

	// reset loads constants only; straps are taken by the clocked path
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= STATE_RST;
		else
			state <= next_state;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	// bus answer
	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.rdat;

	// decoded configuration, straight from the register
	assign cfg_valid_o         = state.captured;
	assign direct_led_mode_o   = state.cfg.direct_led;
	assign led_mode_o          = state.cfg.led_mode;
	assign copper_flow_ctrl_o  = state.cfg.copper_flow;
	assign fiber_flow_ctrl_o   = state.cfg.fiber_flow;
	assign fiber_full_duplex_o = state.cfg.fiber_dup;
	assign repeater_mode_o     = state.cfg.repeater;
	assign forced_led_on_o     = state.cfg.forced_led;
	assign phy_addr_hi_o       = state.cfg.addr_hi;
	assign rx_delay_en_o       = state.cfg.rx_delay;
	assign tx_delay_en_o       = state.cfg.tx_delay;
	assign slew_fast_o         = state.cfg.slew_fast;
	assign test_mode_o         = state.cfg.test_mode;
	assign scan_mode_o         = state.cfg.scan_mode;

	// every led low, or the legacy mix kept for older boards
	assign led_active_low_o = state.cfg.all_low ? 24'hffffff : LEGACY_LOW;

	// reference rate for the rest of the chip
	assign ref_tick_o = ref_tick;

	// management is only announced once the quiet window is over
	assign mgmt_ready_o = state.quiet_done & state.mgmt_enable;

endmodule

// >>> hw/osl_pkg.sv
/*
 * osl_pkg: shared constants and types for the strap configuration latch.
 * assumes one 200 MHz clock and a classic wishbone master outside.
 */
package osl_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int MCLK_MHZ    = 200;                 // system clock rate
	localparam int REF_MHZ     = 25;                  // reference tick rate
	localparam int REF_DIV     = MCLK_MHZ / REF_MHZ;  // mclk cycles per tick
	localparam int QUIET_US    = 700;                 // management quiet time
	localparam int QUIET_TICKS = QUIET_US * REF_MHZ;  // quiet time in ticks
	localparam int QCW         = 16;                  // quiet counter width
	localparam int RESET_LOW_US = 1000;               // least reset low time
	localparam int MDC_MAX_KHZ = 2500;                // fastest management clock
	localparam int TX_DELAY_NS = 4;                   // added transmit clock delay

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam int         WB_AW      = 8;      // wishbone address width
	localparam logic [7:0] REG_CONFIG = 8'h00;  // decoded configuration, ro
	localparam logic [7:0] REG_STRAPS = 8'h04;  // raw latched straps, ro
	localparam logic [7:0] REG_STATUS = 8'h08;  // latch and quiet state, ro
	localparam logic [7:0] REG_CTRL   = 8'h0c;  // management gate, rw

	// status and control bit positions
	localparam int STAT_CAPTURED = 0;  // straps have been latched
	localparam int STAT_QUIET    = 1;  // quiet time has elapsed
	localparam int STAT_READY    = 2;  // management ready output
	localparam int CTRL_ENABLE   = 0;  // gates the ready output
	localparam int CTRL_RESTART  = 1;  // write one restarts quiet time
	localparam logic CTRL_ENABLE_RST = 1'b1;  // gate open after reset

	// ****************************************************************
	// strap encodings and values after reset
	// ****************************************************************
	localparam logic [1:0] LED_DIRECT = 2'b11;  // mono color direct mode

	// raw straps as latched, msb first
	typedef struct packed {
		logic [1:0] led_display;  // led display select
		logic       copper_flow;  // copper flow control
		logic       addr_bit4;    // serial mode address bit 4
		logic       addr_bit3;    // serial mode address bit 3
		logic       active_low;   // led active low select
		logic       repeater;     // repeater select or direct bit 4
		logic       rx_delay;     // receive output delay
		logic       fiber_flow;   // fiber flow control
		logic       test_dis;     // test disable
		logic       forced_led;   // forced mode led or direct bit 3
		logic       fiber_dup;    // fiber duplex
		logic       tx_delay;     // transmit clock delay
		logic       slew_fast;    // fast slew
		logic       scan;         // scan select
	} osl_straps_type;

	localparam osl_straps_type STRAP_RST = '{
		led_display: 2'b00,
		copper_flow: 1'b1,
		addr_bit4:   1'b0,
		addr_bit3:   1'b1,
		active_low:  1'b0,
		repeater:    1'b1,
		rx_delay:    1'b0,
		fiber_flow:  1'b1,
		test_dis:    1'b1,
		forced_led:  1'b0,
		fiber_dup:   1'b1,
		tx_delay:    1'b0,
		slew_fast:   1'b1,
		scan:        1'b0
	};

	// decoded configuration, msb first; bit 0 is direct_led
	typedef struct packed {
		logic       scan_mode;    // bit 15
		logic       test_mode;    // bit 14
		logic       slew_fast;    // bit 13
		logic       tx_delay;     // bit 12
		logic       rx_delay;     // bit 11
		logic       all_low;      // bit 10
		logic [1:0] addr_hi;      // bits 9:8, address bits 4:3
		logic       forced_led;   // bit 7
		logic       repeater;     // bit 6
		logic       fiber_dup;    // bit 5
		logic       fiber_flow;   // bit 4
		logic       copper_flow;  // bit 3
		logic [1:0] led_mode;     // bits 2:1
		logic       direct_led;   // bit 0
	} osl_cfg_type;

endpackage

// >>> hw/osl_tick_div.sv
/*
 * osl_tick_div: divides the system clock into a one-cycle enable pulse.
 * assumes a free running clock and an asynchronous active low reset.
 */
`timescale 1ns/10ps
module osl_tick_div
	import osl_pkg::*;
#(
	parameter int DIV = REF_DIV  // clock cycles per pulse
)
(
	input  wire logic mclk_i,   // system clock
	input  wire logic rst_n_i,  // async reset, active low
	output logic      tick_o    // one-cycle enable pulse
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;  // counter width

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [CW-1:0] cnt;   // cycles since last pulse
		logic          tick;  // registered pulse
	} osl_div_type;

	osl_div_type state;       // current state
	osl_div_type next_state;  // next state

	// count to the end of the period, pulse once per wrap
	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (state.cnt == CW'(DIV - 1))
		begin
			next_state.cnt  = '0;
			next_state.tick = 1'b1;
		end
		else
			next_state.cnt = state.cnt + 1'b1;
	end

	// register the copy
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick_o = state.tick;

endmodule

// >>> dv/osl_strap_latch_chk.sv
/*
 * osl_strap_latch_chk: port-level checks of the strap latch.
 * assumes one clock domain and the async active low reset.
 */
`timescale 1ns/10ps
module osl_strap_latch_chk
	import osl_pkg::*;
#(
	parameter int          QUIET_LEN  = 4,            // quiet time in ticks
	parameter logic [23:0] LEGACY_LOW = 24'h000000    // legacy low leds
)
(
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic [1:0]  led_display_select_i,
	input wire logic        serial_led_addr_bit4_i,
	input wire logic        serial_led_addr_bit3_i,
	input wire logic        led_active_low_select_i,
	input wire logic        repeater_select_i,
	input wire logic        forced_mode_led_select_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_ack_o,
	input wire logic        cfg_valid_o,
	input wire logic        direct_led_mode_o,
	input wire logic [1:0]  led_mode_o,
	input wire logic        copper_flow_ctrl_o,
	input wire logic        fiber_flow_ctrl_o,
	input wire logic        fiber_full_duplex_o,
	input wire logic        repeater_mode_o,
	input wire logic        forced_led_on_o,
	input wire logic [1:0]  phy_addr_hi_o,
	input wire logic [23:0] led_active_low_o,
	input wire logic        ref_tick_o,
	input wire logic        mgmt_ready_o
);
	// ********
	// helper logic
	// ********
	localparam int QMIN = QUIET_LEN * 8 - 10;  // slack for tick phase
	int unsigned qcnt;                          // cycles since capture

	// counts only while latched and is cleared only by reset, so the wait after a restart is not timed
	always_ff @(posedge mclk_i or negedge rst_n_i)
		if (!rst_n_i)
			qcnt <= 0;
		else if (cfg_valid_o)
			qcnt <= qcnt + 1;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// ********
	// assertions
	// ********
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	// rst_n_i in the antecedent skips the attempt on the release edge itself
	capture_once_a: assert property (rst_n_i && !cfg_valid_o |=> cfg_valid_o)
		else $error("straps not latched on first edge");
	serial_cap_a: assert property (rst_n_i && !cfg_valid_o
		&& led_display_select_i != LED_DIRECT |=>
		phy_addr_hi_o == {$past(serial_led_addr_bit4_i), $past(serial_led_addr_bit3_i)}
		&& repeater_mode_o == $past(repeater_select_i)
		&& forced_led_on_o == $past(forced_mode_led_select_i))
		else $error("serial mode decode wrong");
	direct_cap_a: assert property (rst_n_i && !cfg_valid_o
		&& led_display_select_i == LED_DIRECT |=>
		direct_led_mode_o && phy_addr_hi_o ==
		{$past(repeater_select_i), $past(forced_mode_led_select_i)})
		else $error("direct mode address wrong");
	direct_dec_a: assert property (cfg_valid_o |->
		direct_led_mode_o == (led_mode_o == LED_DIRECT) && (!direct_led_mode_o ||
		copper_flow_ctrl_o && fiber_flow_ctrl_o && fiber_full_duplex_o))
		else $error("direct mode defaults wrong");
	polarity_a: assert property (rst_n_i && !cfg_valid_o |=> led_active_low_o ==
		($past(led_active_low_select_i) ? 24'hffffff : LEGACY_LOW))
		else $error("led polarity wrong");
	hold_cfg_a: assert property (cfg_valid_o |=>
		$stable({phy_addr_hi_o, led_active_low_o, repeater_mode_o, forced_led_on_o}))
		else $error("latched config changed");
	ref_tick_a: assert property (ref_tick_o |=> !ref_tick_o [*7] ##1 ref_tick_o)
		else $error("reference tick not every 8 clocks");
	quiet_time_a: assert property ($rose(mgmt_ready_o) |-> cfg_valid_o && qcnt >= QMIN)
		else $error("management ready too early");
endmodule

bind osl_strap_latch osl_strap_latch_chk #(
	.QUIET_LEN  (QUIET_LEN),
	.LEGACY_LOW (LEGACY_LOW)
) chk_i (.*);

// >>> dv/osl_strap_board.sv
/*
 * osl_strap_board: board straps on pins that later serve as leds.
 * assumes the latch samples on the first edge after reset release.
 */
`timescale 1ns/10ps
module osl_strap_board
	import osl_pkg::*;
(
	input  wire logic           mclk_i,     // system clock
	input  wire logic           rst_n_i,    // async reset, active low
	input  wire osl_straps_type set_i,      // resistor settings
	input  wire logic           led_run_i,  // leds start blinking
	output osl_straps_type      pin_o       // levels seen at the pins
);
	logic seen;  // capture edge has passed
	logic flip;  // blink phase

	// track the capture edge and a blink phase
	always_ff @(posedge mclk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			seen <= 1'b0;
			flip <= 1'b0;
		end
		else
		begin
			seen <= 1'b1;
			flip <= ~flip;
		end

	// steady through capture, then every strap pin toggles as an led
	assign pin_o = (seen && led_run_i && flip) ? ~set_i : set_i;
endmodule

// >>> dv/osl_strap_latch_tb.sv
/*
 * osl_strap_latch_tb: strap sets per led mode, quiet window, registers.
 * assumes the board model and checker are compiled alongside.
 */
`timescale 1ns/10ps
module osl_strap_latch_tb
	import osl_pkg::*;
;
	localparam int          QL = 4;             // short quiet time
	localparam logic [23:0] LL = 24'h0f00f0;    // legacy low pattern
	logic           mclk_i  = 1'b0;
	logic           rst_n_i = 1'b0;
	logic           req     = 1'b0;             // cyc and stb together
	logic           we      = 1'b0;
	logic [7:0]     adr     = '0;
	logic [31:0]    dat     = '0;
	logic [31:0]    rd;
	logic [31:0]    q;                          // last read data
	logic           ack;
	logic           ready;
	logic [1:0]     addr_hi;
	logic [23:0]    led_lo;
	logic           led_run = 1'b0;
	osl_straps_type set     = STRAP_RST;
	osl_straps_type pin;
	osl_straps_type tab [5];
	osl_cfg_type    c;
	wire osl_cfg_type o;                        // decoded outputs as seen
	int             failures, cmp_count, cycles;

	always #2.5 mclk_i = ~mclk_i;

	osl_strap_board brd (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(set),
		.led_run_i(led_run), .pin_o(pin));

	osl_strap_latch #(.QUIET_LEN(QL), .LEGACY_LOW(LL)) uut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.led_display_select_i(pin.led_display),
		.copper_flow_ctrl_strap_i(pin.copper_flow),
		.serial_led_addr_bit4_i(pin.addr_bit4),
		.serial_led_addr_bit3_i(pin.addr_bit3),
		.led_active_low_select_i(pin.active_low),
		.repeater_select_i(pin.repeater), .rx_delay_strap_i(pin.rx_delay),
		.fiber_flow_ctrl_strap_i(pin.fiber_flow),
		.test_disable_strap_i(pin.test_dis),
		.forced_mode_led_select_i(pin.forced_led),
		.fiber_duplex_strap_i(pin.fiber_dup), .tx_delay_strap_i(pin.tx_delay),
		.slew_strap_i(pin.slew_fast), .scan_select_strap_i(pin.scan),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.cfg_valid_o(), .direct_led_mode_o(o.direct_led),
		.led_mode_o(o.led_mode), .copper_flow_ctrl_o(o.copper_flow),
		.fiber_flow_ctrl_o(o.fiber_flow), .fiber_full_duplex_o(o.fiber_dup),
		.repeater_mode_o(o.repeater), .forced_led_on_o(o.forced_led),
		.phy_addr_hi_o(addr_hi), .led_active_low_o(led_lo),
		.rx_delay_en_o(o.rx_delay), .tx_delay_en_o(o.tx_delay),
		.slew_fast_o(o.slew_fast), .test_mode_o(o.test_mode),
		.scan_mode_o(o.scan_mode), .ref_tick_o(), .mgmt_ready_o(ready));

	// remaining fields of the output view
	assign o.addr_hi = addr_hi;
	assign o.all_low = &led_lo;  // all ones only when every led is low

	// expected decode, worked out from the strap meanings
	function automatic osl_cfg_type exp_cfg(input osl_straps_type s);
		osl_cfg_type e;
		logic        d;
		d = (s.led_display == LED_DIRECT);
		e.direct_led = d;
		e.led_mode = s.led_display;
		e.copper_flow = d | s.copper_flow;
		e.fiber_flow = d | s.fiber_flow;
		e.fiber_dup = d | s.fiber_dup;
		e.repeater = d | s.repeater;
		e.forced_led = ~d & s.forced_led;
		e.addr_hi = d ? {s.repeater, s.forced_led} : {s.addr_bit4, s.addr_bit3};
		e.all_low = s.active_low;
		e.rx_delay = s.rx_delay;
		e.tx_delay = s.tx_delay;
		e.slew_fast = s.slew_fast;
		e.test_mode = ~s.test_dis;
		e.scan_mode = s.scan;
		return e;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 64);
		q = rd;
		req <= 1'b0;
		we <= 1'b0;
		@(posedge mclk_i);
		if (n >= 64)
			failures++;
	endtask

	// reset with given straps; returns after the capture edge
	task automatic boot(input osl_straps_type s);
		set <= s;
		led_run <= 1'b0;
		rst_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		led_run <= 1'b1;
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 200)
		begin
			@(posedge mclk_i);
			n++;
		end
		chk(32'(n >= QL * 8 - 16 && n <= QL * 8 + 10), 32'h1);
	endtask

	task automatic close_out;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			close_out();
		end
	end

	initial
	begin
		tab[0] = STRAP_RST;
		tab[1] = {2'b01, ~STRAP_RST[12:0]};
		tab[2] = {2'b10, 13'h0b3c};
		tab[3] = {2'b11, ~STRAP_RST[12:0]};
		tab[4] = {2'b11, STRAP_RST[12:0]};
		// every led mode, latched while pins blink afterwards
		foreach (tab[i])
		begin
			c = exp_cfg(tab[i]);
			boot(tab[i]);
			wb(1'b0, REG_CONFIG, '0);
			chk(q, {16'h0, c});
			chk({16'h0, o}, {16'h0, c});
			wb(1'b0, REG_STRAPS, '0);
			chk(q, {17'h0, tab[i]});
			chk({30'h0, addr_hi}, {30'h0, c.addr_hi});
			chk({8'h0, led_lo}, {8'h0, tab[i].active_low ? 24'hffffff : LL});
			repeat (16) @(posedge mclk_i);
			wb(1'b0, REG_CONFIG, '0);
			chk(q, {16'h0, c});
			chk({16'h0, o}, {16'h0, c});
		end
		// quiet window, gate and restart
		boot(STRAP_RST);
		wait_rdy();
		wb(1'b0, REG_STATUS, '0);
		chk(q, 32'h7);
		wb(1'b0, REG_CTRL, '0);
		chk(q, 32'h1);
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b0, REG_STATUS, '0);
		chk(q, 32'h3);
		chk({31'h0, ready}, 32'h0);
		wb(1'b1, REG_CTRL, 32'h3);
		wb(1'b0, REG_STATUS, '0);
		chk(q, 32'h1);
		wait_rdy();
		wb(1'b0, REG_CTRL, '0);
		chk(q, 32'h1);
		// unmapped and read-only places
		wb(1'b0, 8'h10, '0);
		chk(q, 32'h0);
		wb(1'b1, 8'h1c, 32'h0);
		wb(1'b1, REG_CONFIG, 32'hffffffff);
		wb(1'b0, REG_CTRL, '0);
		chk(q, 32'h1);
		wb(1'b0, REG_CONFIG, '0);
		chk(q, {16'h0, exp_cfg(STRAP_RST)});
		close_out();
	end
endmodule
